// file: logic/tmtc_pkg.sv
// package: constants for the trim memory and temperature compensation block
package tmtc_pkg;
  // memory geometry: 135 data bits plus 25 parity bits
  localparam int unsigned DATA_BITS   = 135;
  localparam int unsigned PARITY_BITS = 25;
  localparam int unsigned ROWS        = 10;
  localparam int unsigned COLS        = 15;
  localparam int unsigned ROW_W       = 16;   // 15 data bits plus row parity
  localparam int unsigned ADDR_W      = 4;
  // field positions inside the flat data image
  localparam int unsigned LIN_POS     = 0;
  localparam int unsigned LIN_W       = 9;
  localparam int unsigned QUAD_POS    = 9;
  localparam int unsigned QUAD_W      = 8;
  localparam int unsigned REF_POS     = 17;
  localparam int unsigned REF_W       = 3;
  localparam int unsigned LOCK0_POS   = 20;
  localparam int unsigned LOCK1_POS   = 21;
  // coefficient offsets and scaling
  localparam logic [8:0]  LIN_ZERO    = 9'h0a0;   // 160
  localparam logic [7:0]  QUAD_ZERO   = 8'h80;    // 128
  localparam int signed   REF_SCALE   = 16;
  localparam int signed   REF_BIAS    = 48;
  localparam int unsigned LIN_SHIFT   = 16;       // divide by 65536
  localparam int unsigned QUAD_SHIFT  = 23;       // divide by 8388608
  localparam int unsigned FRAC_W      = 16;       // factor is q.16
  // nonvolatile pulse timing
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned WRITE_MS    = 10;
  localparam int unsigned ERASE_MS    = 80;
  localparam int unsigned WRITE_CYC   = CLK_HZ / 1000 * WRITE_MS;
  localparam int unsigned ERASE_CYC   = CLK_HZ / 1000 * ERASE_MS;
  // link command codes
  localparam logic [2:0]  CMD_RAM_WR  = 3'h1;
  localparam logic [2:0]  CMD_NV_PROG = 3'h2;
  localparam logic [2:0]  CMD_DAC     = 3'h3;
  localparam logic [2:0]  CMD_RUN     = 3'h4;
endpackage

// file: logic/tmtc_sync.sv
// three-stage synchroniser for a single level
`timescale 1ns/10ps
module tmtc_sync (
  // clock and reset
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  // level
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_q, s2_q, s3_q;

  // a change counts once stages two and three agree
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        q_o <= s3_q;
      end
    end
  end
endmodule

// file: logic/tmtc_core.sv
// trim memory with matrix parity, lock and temperature compensation
//
// Summary of operation
// - gain factor is one plus linear times offset plus quadratic times offset squared
// - linear field is 9 bits, coefficient is field minus 160 over 65536
// - quadratic field is 8 bits, coefficient is field minus 128 over 8388608
// - reference temperature is sixteen times 3-bit field minus 48
// - with both lock bits set the memory contents cannot change
// - while locked the link is ignored and application mode persists
// - each row plus its parity bit holds an odd number of ones
// - even column positions across all lines hold an even count
// - odd column positions across all lines hold an odd count
// - row and column checks locate and flip one wrong bit
// - writes land in a RAM shadow that drives operation
// - memory holds 135 data bits and 25 parity bits
// - write pulse lasts 10 ms and erase pulse 80 ms
// - data moves both ways over the supply and output pins
// - devices sharing supply lines are programmed together in parallel
// - converter values readable and a DAC test mode exists
// - an uncorrectable second error forces the supply-level error output
`timescale 1ns/10ps
module tmtc_core
  import tmtc_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC
) (
  // system clock and reset
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  // link clock domain (supply-line clock and output-pin data)
  input  wire logic              link_clk_i,
  input  wire logic              link_data_i,
  output logic                   link_data_o,
  output logic                   link_data_oe_o,
  // nonvolatile array read port
  input  wire logic [ROW_W-1:0]  nv_rdata_i [ROWS],
  // nonvolatile pulses
  output logic                   nv_write_o,
  output logic                   nv_erase_o,
  // signal path
  input  wire logic              temp_valid_i,
  input  wire logic signed [7:0] temp_i,
  input  wire logic signed [15:0] hall_i,
  input  wire logic [15:0]       adc_i,
  output logic signed [15:0]     out_o,
  output logic                   error_o,
  output logic                   dac_test_o,
  output logic                   locked_o
);
  // elaboration checks: a zero-length pulse would wrap the count and hold the sequencer for 2^32 cycles
  if (WRITE_CYCLES == 0 || ERASE_CYCLES == 0) begin : g_bad_pulse
    $error("pulse lengths must be nonzero");
  end
  // geometry must give 135 data bits and 25 parity bits
  if ((ROWS - 1) * COLS != DATA_BITS || ROWS + COLS != PARITY_BITS) begin : g_bad_geom
    $error("memory geometry does not match the bit counts");
  end

  typedef enum logic [1:0] {TMTC_IDLE, TMTC_ERASE, TMTC_WRITE} tmtc_nv_e;

  // link domain: 24-bit frame shift register, command, row, 16 data bits
  logic [23:0] lk_shift_q;
  logic [4:0]  lk_cnt_q;
  logic [23:0] lk_word_q;
  logic        lk_tog_q;
  logic [15:0] lk_tx_q;
  logic [15:0] rsp_q;

  // frames shift in on the link clock; response shifts out
  always_ff @(posedge link_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lk_shift_q <= 24'h000000;
      lk_cnt_q   <= 5'h00;
      lk_word_q  <= 24'h000000;
      lk_tog_q   <= 1'b0;
      lk_tx_q    <= 16'h0000;
    end else begin
      lk_shift_q <= {lk_shift_q[22:0], link_data_i};
      lk_tx_q    <= {lk_tx_q[14:0], 1'b0};
      if (lk_cnt_q == 5'h17) begin
        lk_cnt_q  <= 5'h00;
        lk_word_q <= {lk_shift_q[22:0], link_data_i};
        lk_tog_q  <= ~lk_tog_q;
        lk_tx_q   <= rsp_q;     // quasi-static response, stable between frames
      end else begin
        lk_cnt_q <= lk_cnt_q + 5'h01;
      end
    end
  end

  // pin is driven only while answering, so parallel devices share the bus
  assign link_data_o    = lk_tx_q[15];
  assign link_data_oe_o = (lk_word_q[23:21] == 3'h0) && !locked_o;

  // word crossing: toggle synchronised, word stable until the next frame ends;
  // the sync takes up to five system clocks, so frames must be spaced by at
  // least that much or a later frame overwrites the word before it is used
  logic tog_s;
  logic tog_seen_q;
  logic frame_p;
  tmtc_sync u_tog (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .d_i       (lk_tog_q),
    .q_o       (tog_s)
  );
  assign frame_p = tog_s != tog_seen_q;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tog_seen_q <= 1'b0;
    end else begin
      tog_seen_q <= tog_s;
    end
  end

  logic [2:0]        cmd;
  logic [ADDR_W-1:0] row_sel;
  logic [15:0]       wdata;
  assign cmd     = lk_word_q[23:21];
  assign row_sel = lk_word_q[19:16];
  assign wdata   = lk_word_q[15:0];

  // shadow RAM, loaded from the corrected array after reset
  logic [ROW_W-1:0] ram_q [ROWS];
  logic [ROW_W-1:0] fix   [ROWS];
  logic             loaded_q;
  logic             locked;
  logic             uncorr;

  // row parity odd, column parity by position
  logic [ROWS-1:0]  row_bad;
  logic [ROW_W-1:0] col_acc;
  logic [ROW_W-1:0] col_bad;
  genvar gr;
  generate
    for (gr = 0; gr < ROWS; gr++) begin : g_row
      assign row_bad[gr] = ~^nv_rdata_i[gr];
    end
  endgenerate

  always_comb begin
    col_acc = '0;
    for (int r = 0; r < ROWS; r++) begin
      col_acc = col_acc ^ nv_rdata_i[r];
    end
    for (int c = 0; c < COLS; c++) begin
      col_bad[c] = (c % 2 == 0) ? col_acc[c] : ~col_acc[c];
    end
    // the row parity column has no column check: its corner bit cannot serve both
    col_bad[ROW_W-1] = 1'b0;
  end

  // flip the bit where exactly one row and one column disagree
  always_comb begin
    for (int r = 0; r < ROWS; r++) begin
      fix[r] = nv_rdata_i[r];
      if (row_bad[r] && $countones(row_bad) == 1 && $countones(col_bad) == 1) begin
        fix[r] = nv_rdata_i[r] ^ col_bad;
      end
    end
  end

  // more than one row or column flagged is not correctable
  assign uncorr = ($countones(row_bad) > 1) || ($countones(col_bad) > 1);

  // both redundant lock bits must be set
  assign locked = ram_q[LOCK0_POS / COLS][LOCK0_POS % COLS]
               && ram_q[LOCK1_POS / COLS][LOCK1_POS % COLS];
  assign locked_o = locked && loaded_q;

  // nonvolatile sequencer, erase then write
  tmtc_nv_e    nv_q;
  logic [31:0] nv_cnt_q;

  // pulse widths counted in system clocks
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nv_q     <= TMTC_IDLE;
      nv_cnt_q <= 32'h00000000;
    end else begin
      case (nv_q)
        TMTC_IDLE: begin
          if (frame_p && cmd == CMD_NV_PROG && !locked_o && loaded_q) begin
            nv_q     <= TMTC_ERASE;
            nv_cnt_q <= ERASE_CYCLES - 1;
          end
        end
        TMTC_ERASE: begin
          if (nv_cnt_q == 32'h00000000) begin
            nv_q     <= TMTC_WRITE;
            nv_cnt_q <= WRITE_CYCLES - 1;
          end else begin
            nv_cnt_q <= nv_cnt_q - 32'h00000001;
          end
        end
        TMTC_WRITE: begin
          if (nv_cnt_q == 32'h00000000) begin
            nv_q <= TMTC_IDLE;
          end else begin
            nv_cnt_q <= nv_cnt_q - 32'h00000001;
          end
        end
        default: nv_q <= TMTC_IDLE;
      endcase
    end
  end
  assign nv_erase_o = nv_q == TMTC_ERASE;
  assign nv_write_o = nv_q == TMTC_WRITE;

  // trial settings go to the shadow only; array is untouched
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loaded_q <= 1'b0;
      for (int r = 0; r < ROWS; r++) begin
        ram_q[r] <= '0;
      end
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      for (int r = 0; r < ROWS; r++) begin
        ram_q[r] <= fix[r];
      end
    end else if (frame_p && cmd == CMD_RAM_WR && !locked_o && row_sel < ROWS) begin
      ram_q[row_sel] <= wdata;
    end
  end

  // test mode flag and readback of rows and converter value
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dac_test_o <= 1'b0;
      rsp_q      <= 16'h0000;
    end else begin
      if (locked_o) begin
        dac_test_o <= 1'b0;
      end else if (frame_p && cmd == CMD_DAC) begin
        dac_test_o <= 1'b1;
      end else if (frame_p && cmd == CMD_RUN) begin
        dac_test_o <= 1'b0;
      end
      if (frame_p && cmd == 3'h0) begin
        rsp_q <= (row_sel < ROWS) ? ram_q[row_sel] : adc_i;
      end
    end
  end

  // decoded fields from the flat shadow image
  logic [DATA_BITS-1:0] flat;
  always_comb begin
    for (int i = 0; i < DATA_BITS; i++) begin
      flat[i] = ram_q[i / COLS][i % COLS];
    end
  end

  logic signed [9:0]  lin_c;
  logic signed [8:0]  quad_c;
  logic signed [8:0]  ref_t;
  assign lin_c  = $signed({1'b0, flat[LIN_POS +: LIN_W]}) - $signed({1'b0, LIN_ZERO});
  assign quad_c = $signed({1'b0, flat[QUAD_POS +: QUAD_W]}) - $signed({1'b0, QUAD_ZERO});
  assign ref_t  = 9'(REF_SCALE * $signed({1'b0, flat[REF_POS +: REF_W]}) - REF_BIAS);

  // factor in q.16, updated per temperature sample
  logic signed [9:0]  dt;
  logic signed [47:0] lin_t;
  logic signed [47:0] quad_t;
  logic signed [47:0] fac;
  logic signed [23:0] fac_q;
  assign dt     = 10'($signed(temp_i)) - 10'(ref_t);
  // operands widened first so the products cannot wrap at ten bits
  assign lin_t  = (48'(lin_c) * 48'(dt)) <<< (FRAC_W - LIN_SHIFT);
  assign quad_t = (48'(quad_c) * 48'(dt) * 48'(dt)) >>> (QUAD_SHIFT - FRAC_W);
  assign fac    = (48'sh1 <<< FRAC_W) + lin_t + quad_t;

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fac_q <= 24'sh010000;
    end else if (temp_valid_i) begin
      fac_q <= fac[23:0];
    end
  end

  // hall scaling; error forces full scale output
  logic signed [39:0] prod;
  assign prod = hall_i * fac_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_o   <= 16'sh0000;
      error_o <= 1'b0;
    end else begin
      error_o <= uncorr;
      out_o   <= uncorr ? 16'sh7fff : prod[31:16];
    end
  end
endmodule

// file: tb/tmtc_core_monitor.sv
// checker: port assertions for the trim memory block
`timescale 1ns/10ps
module tmtc_core_monitor
  import tmtc_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CYC,
  parameter int unsigned ERASE_CYCLES = ERASE_CYC
) (
  // clock, reset, input
  input wire logic               clock_i,
  input wire logic               reset_n_i,
  input wire logic               temp_valid_i,
  // watched outputs
  input wire logic               link_data_oe_o,
  input wire logic               nv_write_o,
  input wire logic               nv_erase_o,
  input wire logic signed [15:0] out_o,
  input wire logic               error_o,
  input wire logic               dac_test_o,
  input wire logic               locked_o
);
  logic [19:0] er_q;
  logic [19:0] wr_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // pulse length counters, cleared between pulses
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      er_q <= '0;
      wr_q <= '0;
    end else begin
      er_q <= nv_erase_o ? er_q + 20'h1 : '0;
      wr_q <= nv_write_o ? wr_q + 20'h1 : '0;
    end
  end
  sequence s_erase_end;
    $fell(nv_erase_o);
  endsequence
  sequence s_write_on;
    nv_write_o ##1 nv_write_o;
  endsequence
  AST_NV_EXCL: assert property (!(nv_write_o && nv_erase_o)) else $error("erase and write overlap");
  AST_ERASE_LEN: assert property ($fell(nv_erase_o) |-> er_q == ERASE_CYCLES) else $error("erase length");
  AST_WRITE_LEN: assert property ($fell(nv_write_o) |-> wr_q == WRITE_CYCLES) else $error("write length");
  AST_ERASE_THEN_WRITE: assert property (s_erase_end |-> s_write_on) else $error("write not after erase");
  AST_LOCK_HOLD: assert property (locked_o |=> locked_o) else $error("lock dropped");
  AST_LOCK_NO_OE: assert property (locked_o |-> !link_data_oe_o) else $error("link driven while locked");
  AST_LOCK_NO_PROG: assert property ($rose(nv_erase_o) |-> !$past(locked_o)) else $error("program while locked");
  AST_LOCK_NO_DAC: assert property ($rose(dac_test_o) |-> !$past(locked_o)) else $error("dac test while locked");
  AST_ERR_OUT: assert property (error_o && temp_valid_i |-> ##[1:8] out_o == 16'sh7fff) else $error("no error level");
  AST_ERR_LEVEL: assert property (error_o |-> out_o == 16'sh7fff) else $error("error level missing");
endmodule
bind tmtc_core tmtc_core_monitor #(.WRITE_CYCLES(WRITE_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_mon (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .temp_valid_i(temp_valid_i), .link_data_oe_o(link_data_oe_o),
  .nv_write_o(nv_write_o), .nv_erase_o(nv_erase_o), .out_o(out_o), .error_o(error_o),
  .dac_test_o(dac_test_o), .locked_o(locked_o));

// file: tb/tmtc_prog.sv
// programmer model: frames on the supply-line link
`timescale 1ns/10ps
module tmtc_prog
  import tmtc_pkg::*;
(
  // link towards the device
  output logic      link_clk_o,
  output logic      link_data_o,
  // answer from the device output pin
  input  wire logic link_data_i
);
  int unsigned nprog;
  logic [15:0] rx;
  initial begin
    link_clk_o = 1'b0;
    link_data_o = 1'b0;
    nprog = 0;
    rx = 16'h0000;
  end
  // serial frame, clock still between frames
  task automatic send(input logic [2:0] cmd, input logic [3:0] row, input logic [15:0] dat);
    logic [23:0] fr;
    fr = {cmd, 1'b0, row, dat};
    // gap lets the device take the previous frame before its word is overwritten
    #800;
    for (int i = 23; i >= 0; i--) begin
      link_data_o = fr[i];
      // answer bits stand before each rising edge, msb first, in the first 16 bits
      if (i >= 8) begin
        rx = {rx[14:0], link_data_i};
      end
      #6 link_clk_o = 1'b1;
      #6 link_clk_o = 1'b0;
    end
    // idle line must not repeat the last bit
    link_data_o = ~fr[0];
  endtask
  // limited program cycles, caller waits out the pulses
  task automatic program_nv();
    if (nprog < 10) begin
      nprog++;
      send(CMD_NV_PROG, 4'h0, 16'h0000);
    end
  endtask
endmodule

// file: tb/tmtc_core_tb.sv
// testbench: random trims, link writes, programming, lock, errors
`timescale 1ns/10ps
module tmtc_core_tb
  import tmtc_pkg::*;
;
  logic clock_i, reset_n_i, temp_valid_i, lclk, ldat, ldo, loe, nvw, nve, error_o, dac_o, locked_o;
  logic signed [7:0] temp_i;
  logic signed [15:0] hall_i, out_o;
  logic [15:0] adc_i, rnd;
  logic [ROW_W-1:0] nv [ROWS];
  logic [ROW_W-1:0] old [ROWS];
  logic [134:0] img, keep;
  int miscompares, compares, cyc, n;
  tmtc_core #(.WRITE_CYCLES(10), .ERASE_CYCLES(80)) dut (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .link_clk_i(lclk), .link_data_i(ldat), .link_data_o(ldo), .link_data_oe_o(loe), .nv_rdata_i(nv),
    .nv_write_o(nvw), .nv_erase_o(nve), .temp_valid_i(temp_valid_i), .temp_i(temp_i), .hall_i(hall_i),
    .adc_i(adc_i), .out_o(out_o), .error_o(error_o), .dac_test_o(dac_o), .locked_o(locked_o));
  // released pin shows the inverse so a missing drive is seen
  tmtc_prog prog (.link_clk_o(lclk), .link_data_o(ldat), .link_data_i(loe ? ldo : ~ldo));
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // scaled hall value from the trim fields
  function automatic logic signed [15:0] expo(input logic [134:0] f, input logic signed [7:0] t,
                                               input logic signed [15:0] h);
    longint o, fc;
    o = t - (16 * longint'(f[19:17]) - 48);
    fc = 65536 + (longint'(f[8:0]) - 160) * o + (((longint'(f[16:9]) - 128) * o * o) >>> 7);
    return 16'((h * fc) >>> 16);
  endfunction
  task automatic step();
    @(posedge clock_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h got %h", nm, e, g);
    end
  endtask
  // array image with row and column parity
  task automatic mk(input logic [134:0] f);
    logic [14:0] cp;
    cp = 15'h2aaa;
    for (int r = 0; r < 9; r++) begin
      nv[r][14:0] = f[r*15+:15];
      cp ^= f[r*15+:15];
    end
    nv[9][14:0] = cp;
    for (int r = 0; r < 10; r++) nv[r][15] = ~^nv[r][14:0];
    img = f;
  endtask
  task automatic newimg(input logic lk);
    logic [134:0] f;
    for (int i = 0; i < 9; i++) begin
      rnd = lfsr(rnd);
      f[i*15+:15] = rnd[14:0];
    end
    f[21:20] = {2{lk}};
    mk(f);
  endtask
  // rows holding fields, lock and column parity
  task automatic push();
    prog.send(CMD_RAM_WR, 4'h0, nv[0]);
    prog.send(CMD_RAM_WR, 4'h1, nv[1]);
    prog.send(CMD_RAM_WR, 4'h9, nv[9]);
    repeat (6) step();
  endtask
  task automatic rst();
    reset_n_i = 1'b0;
    repeat (2) step();
    reset_n_i = 1'b1;
    repeat (2) step();
  endtask
  task automatic upd(input logic signed [7:0] dt);
    logic signed [7:0] t;
    logic signed [15:0] e;
    rnd = lfsr(rnd);
    t = 8'(16 * img[19:17] - 48) + dt;
    e = expo(img, t, rnd >>> 2);
    temp_i = t;
    hall_i = rnd >>> 2;
    adc_i = rnd;
    temp_valid_i = 1'b1;
    step();
    temp_valid_i = 1'b0;
    repeat (8) step();
    chk("out_o", 32'(e), 32'(out_o));
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    {temp_valid_i, temp_i, hall_i, adc_i, miscompares, compares, cyc} = '0;
    reset_n_i = 1'b0;
    rnd = 16'h0018;
    mk({115'h0, 3'h3, 8'h80, 9'h0a0});
    repeat (10) @(posedge clock_i);
    #1 reset_n_i = 1'b1;
    repeat (2) step();
    // neutral coefficients pass the signal unchanged
    upd(8'sd0);
    for (int k = 0; k < 4; k++) begin
      newimg(1'b0);
      rst();
      upd(8'(rnd[4:0]) - 8'sd16);
    end
    nv[3][7] = ~nv[3][7];
    rst();
    upd(8'sd5);
    chk("error_o", 0, error_o);
    // corrected row and converter value read back over the link
    repeat (3) prog.send(3'h0, 4'h3, 16'h0000);
    chk("row3_read", nv[3] ^ 16'h0080, prog.rx);
    chk("oe_read", 1, loe);
    repeat (3) prog.send(3'h0, 4'hf, 16'h0000);
    chk("adc_read", adc_i, prog.rx);
    old = nv;
    newimg(1'b0);
    push();
    nv = old;
    upd(-8'sd7);
    prog.send(CMD_DAC, 4'h0, 16'h0000);
    repeat (6) step();
    chk("dac_test_o", 1, dac_o);
    prog.send(CMD_RUN, 4'h0, 16'h0000);
    prog.program_nv();
    for (n = 0; n < 50 && !nve; n++) step();
    for (n = 0; nve; n++) step();
    chk("erase_len", 80, n);
    for (n = 0; nvw; n++) step();
    chk("write_len", 10, n);
    newimg(1'b1);
    push();
    rst();
    keep = img;
    chk("locked_o", 1, locked_o);
    chk("oe", 0, loe);
    newimg(1'b0);
    push();
    prog.send(CMD_DAC, 4'h0, 16'h0000);
    prog.program_nv();
    repeat (20) step();
    chk("dac_locked", 0, dac_o);
    chk("erase_locked", 0, nve);
    img = keep;
    upd(8'sd9);
    newimg(1'b0);
    nv[2][4] = ~nv[2][4];
    nv[6][9] = ~nv[6][9];
    rst();
    temp_valid_i = 1'b1;
    step();
    temp_valid_i = 1'b0;
    repeat (8) step();
    chk("error_o", 1, error_o);
    chk("out_err", 32'h7fff, out_o);
    stop_test();
  end
endmodule
